// ---- hw/icl_map.svh ----
/*
 * Register map, field positions, reset values and timing figures of the
 * inclinometer output-data and operation-control block.
 * Assumes a 125 MHz reference clock and byte addresses on a 6-bit serial
 * address field; 16-bit registers hold their low byte at the even address.
 */
// Summary of operation
// - output words carry new-data bit 15, error bit 14, then 14 data bits, or two zero bits and 12 data bits
// - new-data clears on an output register read, sets on next sample update
// - error bit set while any status cause flag is set
// - supply result is 12-bit unsigned, 1.22 mV per code
// - acceleration, inclination, rotation are 14-bit two's complement
// - auxiliary input result is 12-bit unsigned, 0.6105 mV per code
// - temperature result is 12-bit unsigned, -0.47 degC per code
// - sample period is time base times increment plus one
// - time base is 244.14 us when bit 7 clear, 7.568 ms when set
// - sleep register count puts the device asleep for count half-seconds
// - a timed sleep ends early only by reset, never by serial access
// - averaging length is two to the setting; setting at most 8, reset 4
// - digital lines serve data-ready first, then alarm, then general use
// - control bit 2 enables data-ready, bit 1 polarity, bit 0 line
// - data-ready pulse is active for one fifth of the sample period
// - control bit 8 starts a manual self-test, bit 10 skips power-on test
// - failed start-up or manual self-test sets the self-test status flag
// - line control bits 1 and 0 set line directions, 1 is output
// - line control bits 9 and 8 hold line data, read back line levels
`ifndef ICL_MAP_SVH
`define ICL_MAP_SVH

`define ICL_ADDR_SUPPLY 6'h02
`define ICL_ADDR_XACCEL 6'h04
`define ICL_ADDR_YACCEL 6'h06
`define ICL_ADDR_AUX 6'h08
`define ICL_ADDR_TEMP 6'h0a
`define ICL_ADDR_XINCL 6'h0c
`define ICL_ADDR_YINCL 6'h0e
`define ICL_ADDR_ROT 6'h10
`define ICL_ADDR_LINE 6'h32
`define ICL_ADDR_MSC 6'h34
`define ICL_ADDR_SMPL 6'h36
`define ICL_ADDR_AVG 6'h38
`define ICL_ADDR_SLEEP 6'h3a
`define ICL_ADDR_STATUS 6'h3c

`define ICL_RST_SMPL 8'h01
`define ICL_RST_AVG 4'h4
`define ICL_AVG_MAX 4'h8

`define ICL_SMPL_TB_BIT 7
`define ICL_MSC_SEL_BIT 0
`define ICL_MSC_POL_BIT 1
`define ICL_MSC_EN_BIT 2
`define ICL_MSC_MAN_HI_BIT 0
`define ICL_MSC_POST_HI_BIT 2
`define ICL_FLAG_FRESH 15
`define ICL_FLAG_FAULT 14

`define ICL_FRAME_WR_BIT 15
`define ICL_FRAME_LAST 4'hf

`define ICL_CLK_NS 8
`define ICL_TB_FAST_NS 244140
`define ICL_TB_SLOW_NS 7568000
`define ICL_HALF_SEC_NS 500000000
`define ICL_DRDY_DUTY_DIV 5

`endif

// ---- hw/icl_pkg.sv ----
/*
 * Types shared by the inclinometer output-control block.
 * Assumes the front end presents one complete result set per sample.
 */
package icl_pkg;

    typedef logic [15:0] icl_word_t;

    // one sample of every result, raw data bits only
    typedef struct packed {
        logic [11:0] supply;
        logic [13:0] x_accel;
        logic [13:0] y_accel;
        logic [11:0] aux;
        logic [11:0] temp;
        logic [13:0] x_incl;
        logic [13:0] y_incl;
        logic [13:0] rot;
    } icl_sample_s;

    // serial port pins as seen by the device
    typedef struct packed {
        logic sclk;
        logic cs_n;
        logic mosi;
    } icl_spi_s;

    // two digital lines, pin side
    typedef struct packed {
        logic [1:0] level;
        logic [1:0] oe;
    } icl_line_s;

    typedef enum logic {ICL_ST_IDLE, ICL_ST_RUN} icl_selftest_e;

endpackage

// ---- hw/icl_output_control.sv ----
/*
 * Output-data and operation-control logic of a dual-axis inclinometer:
 * serial register port, sample timer, sleep timer, self-test control,
 * data-ready generation and the two shared digital lines.
 * Assumes all inputs are synchronous to ref_clk, the serial port runs in
 * clock-idle-high mode well below ref_clk, and the front end converts and
 * runs the self-test on request.
 */
`include "icl_map.svh"

module icl_output_control #(
    parameter int TB_FAST_CYCLES = `ICL_TB_FAST_NS / `ICL_CLK_NS,
    parameter int TB_SLOW_CYCLES = `ICL_TB_SLOW_NS / `ICL_CLK_NS,
    parameter int HALF_SEC_CYCLES = `ICL_HALF_SEC_NS / `ICL_CLK_NS
) (
    input logic ref_clk,
    input logic rst,
    input icl_pkg::icl_spi_s spi_in,
    output logic spi_miso,
    input icl_pkg::icl_sample_s sample_in,
    output logic sample_strobe,
    input logic [3:0] fault_causes,
    output logic [3:0] avg_power,
    output logic asleep,
    output logic selftest_run,
    input logic selftest_done,
    input logic selftest_fail,
    input logic [1:0] alarm_drive,
    input logic [1:0] alarm_level,
    input logic [1:0] line_in,
    output icl_pkg::icl_line_s line_pin
);

    // 14 data bits behind the two flag bits
    function automatic icl_pkg::icl_word_t fmt14(input logic fresh, input logic fault,
                                                 input logic [13:0] d);
        return {fresh, fault, d};
    endfunction
    // 12 data bits, the two upper data bits read zero
    function automatic icl_pkg::icl_word_t fmt12(input logic fresh, input logic fault,
                                                 input logic [11:0] d);
        return {fresh, fault, 2'h0, d};
    endfunction
    // sample period in clock cycles from the period setting
    function automatic logic [27:0] period_cycles(input logic [7:0] cfg);
        logic [27:0] base;
        logic [27:0] mult;
        base = cfg[`ICL_SMPL_TB_BIT] ? 28'(TB_SLOW_CYCLES) : 28'(TB_FAST_CYCLES);
        mult = 28'({1'b0, cfg[6:0]}) + 28'h0000001;
        return 28'(base * mult);
    endfunction

    function automatic logic is_output_addr(input logic [5:0] a);
        return (a >= `ICL_ADDR_SUPPLY) && (a <= (`ICL_ADDR_ROT | 6'h01));
    endfunction

    // serial port state
    logic sclk_q, next_sclk_q;
    logic [3:0] bit_cnt, next_bit_cnt;
    logic [15:0] in_shift, next_in_shift;
    logic [15:0] out_shift, next_out_shift;
    // register state
    logic [7:0] smpl_cfg, next_smpl_cfg;
    logic [3:0] avg_cfg, next_avg_cfg;
    logic [2:0] drdy_cfg, next_drdy_cfg;
    logic post_dis, next_post_dis;
    logic [1:0] line_dir, next_line_dir;
    logic [1:0] line_dat, next_line_dat;
    logic fresh, next_fresh;
    icl_pkg::icl_sample_s sample_q, next_sample_q;
    // sample timer
    logic [27:0] smp_cnt, next_smp_cnt;
    logic drdy_armed, next_drdy_armed;
    logic sample_tick;
    logic drdy_act;
    logic [27:0] cur_period;
    // sleep timer
    logic [7:0] slp_left, next_slp_left;
    logic [31:0] half_cnt, next_half_cnt;
    // self-test
    icl_pkg::icl_selftest_e st_state, next_st_state;
    logic st_manual, next_st_manual;
    logic st_err, next_st_err;
    logic post_pending, next_post_pending;
    // lines
    icl_pkg::icl_line_s line_q, next_line_q;
    // decoded frame
    logic sclk_rise, sclk_fall, frame_done;
    logic [15:0] frame;
    logic [5:0] frame_addr;
    logic wr_en, rd_done, man_start;
    logic [15:0] status_word, rd_data;
    logic fault_any;

    assign sclk_rise = spi_in.sclk && !sclk_q && !spi_in.cs_n;
    assign sclk_fall = !spi_in.sclk && sclk_q && !spi_in.cs_n;
    assign frame = {in_shift[14:0], spi_in.mosi};
    assign frame_done = sclk_rise && (bit_cnt == `ICL_FRAME_LAST);
    assign frame_addr = frame[13:8];
    assign wr_en = frame_done && frame[`ICL_FRAME_WR_BIT];
    assign rd_done = frame_done && !frame[`ICL_FRAME_WR_BIT];
    assign status_word = {11'h000, fault_causes, st_err};
    assign fault_any = |status_word;
    assign cur_period = period_cycles(smpl_cfg);
    assign asleep = (slp_left != 8'h00);
    assign sample_tick = !asleep && ((smp_cnt + 28'h0000001) >= cur_period);
    assign sample_strobe = sample_tick;
    assign avg_power = avg_cfg;
    assign selftest_run = (st_state == icl_pkg::ICL_ST_RUN);
    assign spi_miso = out_shift[15];
    assign line_pin = line_q;
    assign man_start = wr_en && (frame_addr == (`ICL_ADDR_MSC | 6'h01))
                       && frame[`ICL_MSC_MAN_HI_BIT];

    // one-fifth duty: active while elapsed * 5 is below the period
    always_comb begin
        logic [30:0] scaled;
        scaled = 31'({smp_cnt, 2'b00}) + 31'(smp_cnt);
        drdy_act = drdy_armed && (scaled < 31'(cur_period));
    end
    // read-back mux, word address ignores the byte select bit
    always_comb begin
        logic [5:0] wa;
        wa = {frame_addr[5:1], 1'b0};
        unique case (wa)
            `ICL_ADDR_SUPPLY: rd_data = fmt12(fresh, fault_any, sample_q.supply);
            `ICL_ADDR_XACCEL: rd_data = fmt14(fresh, fault_any, sample_q.x_accel);
            `ICL_ADDR_YACCEL: rd_data = fmt14(fresh, fault_any, sample_q.y_accel);
            `ICL_ADDR_AUX: rd_data = fmt12(fresh, fault_any, sample_q.aux);
            `ICL_ADDR_TEMP: rd_data = fmt12(fresh, fault_any, sample_q.temp);
            `ICL_ADDR_XINCL: rd_data = fmt14(fresh, fault_any, sample_q.x_incl);
            `ICL_ADDR_YINCL: rd_data = fmt14(fresh, fault_any, sample_q.y_incl);
            `ICL_ADDR_ROT: rd_data = fmt14(fresh, fault_any, sample_q.rot);
            `ICL_ADDR_LINE: rd_data = {6'h00, line_in, 6'h00, line_dir};
            `ICL_ADDR_MSC: rd_data = {5'h00, post_dis, 1'b0, st_manual, 5'h00, drdy_cfg};
            `ICL_ADDR_SMPL: rd_data = {8'h00, smpl_cfg};
            `ICL_ADDR_AVG: rd_data = {12'h000, avg_cfg};
            `ICL_ADDR_STATUS: rd_data = status_word;
            default: rd_data = 16'h0000;
        endcase
    end
    // serial shifter: sample on rising edge, shift out on falling edge
    always_comb begin
        next_sclk_q = spi_in.sclk;
        next_bit_cnt = bit_cnt;
        next_in_shift = in_shift;
        next_out_shift = out_shift;
        if (spi_in.cs_n) begin
            next_bit_cnt = 4'h0;
        end else if (sclk_rise) begin
            next_in_shift = frame;
            next_bit_cnt = bit_cnt + 4'h1;
            if (rd_done) begin
                next_out_shift = rd_data;
            end
        end else if (sclk_fall && (bit_cnt != 4'h0)) begin // first fall only opens the msb
            next_out_shift = {out_shift[14:0], 1'b0};
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sclk_q <= 1'b1;
            bit_cnt <= 4'h0;
            in_shift <= 16'h0000;
            out_shift <= 16'h0000;
        end else begin
            sclk_q <= next_sclk_q;
            bit_cnt <= next_bit_cnt;
            in_shift <= next_in_shift;
            out_shift <= next_out_shift;
        end
    end
    // byte writes into control registers, sample capture, new-data flag
    always_comb begin
        next_smpl_cfg = smpl_cfg;
        next_avg_cfg = avg_cfg;
        next_drdy_cfg = drdy_cfg;
        next_post_dis = post_dis;
        next_line_dir = line_dir;
        next_line_dat = line_dat;
        next_sample_q = sample_q;
        next_fresh = fresh;
        if (wr_en) begin
            unique case (frame_addr)
                `ICL_ADDR_SMPL: next_smpl_cfg = frame[7:0];
                `ICL_ADDR_AVG: begin
                    next_avg_cfg = (frame[3:0] > `ICL_AVG_MAX) ? `ICL_AVG_MAX : frame[3:0];
                end
                `ICL_ADDR_MSC: next_drdy_cfg = frame[2:0];
                (`ICL_ADDR_MSC | 6'h01): next_post_dis = frame[`ICL_MSC_POST_HI_BIT];
                `ICL_ADDR_LINE: next_line_dir = frame[1:0];
                (`ICL_ADDR_LINE | 6'h01): next_line_dat = frame[1:0];
                default: ;
            endcase
        end
        if (rd_done && is_output_addr(frame_addr)) begin
            next_fresh = 1'b0;
        end
        if (sample_tick) begin
            next_sample_q = sample_in;
            next_fresh = 1'b1; // set wins over a same-cycle read
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            smpl_cfg <= `ICL_RST_SMPL;
            avg_cfg <= `ICL_RST_AVG;
            drdy_cfg <= 3'h0;
            post_dis <= 1'b0;
            line_dir <= 2'h0;
            line_dat <= 2'h0;
            sample_q <= '0;
            fresh <= 1'b0;
        end else begin
            smpl_cfg <= next_smpl_cfg;
            avg_cfg <= next_avg_cfg;
            drdy_cfg <= next_drdy_cfg;
            post_dis <= next_post_dis;
            line_dir <= next_line_dir;
            line_dat <= next_line_dat;
            sample_q <= next_sample_q;
            fresh <= next_fresh;
        end
    end
    // sample timer, cleared while asleep; arms data-ready after first update
    always_comb begin
        next_smp_cnt = smp_cnt;
        next_drdy_armed = drdy_armed;
        if (asleep) begin
            next_smp_cnt = 28'h0000000;
            next_drdy_armed = 1'b0;
        end else if (sample_tick) begin
            next_smp_cnt = 28'h0000000;
            next_drdy_armed = 1'b1;
        end else begin
            next_smp_cnt = smp_cnt + 28'h0000001;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            smp_cnt <= 28'h0000000;
            drdy_armed <= 1'b0;
        end else begin
            smp_cnt <= next_smp_cnt;
            drdy_armed <= next_drdy_armed;
        end
    end

    // timed sleep: sleep register writes while asleep are ignored, only reset cuts it short
    always_comb begin
        next_slp_left = slp_left;
        next_half_cnt = half_cnt;
        if (asleep) begin
            if (half_cnt == 32'(HALF_SEC_CYCLES - 1)) begin
                next_half_cnt = 32'h00000000;
                next_slp_left = slp_left - 8'h01;
            end else begin
                next_half_cnt = half_cnt + 32'h00000001;
            end
        end else if (wr_en && (frame_addr == `ICL_ADDR_SLEEP)) begin
            next_slp_left = frame[7:0];
            next_half_cnt = 32'h00000000;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            slp_left <= 8'h00;
            half_cnt <= 32'h00000000;
        end else begin
            slp_left <= next_slp_left;
            half_cnt <= next_half_cnt;
        end
    end

    // self-test sequencing: power-on test waits for the first sample update
    always_comb begin
        next_st_state = st_state;
        next_st_manual = st_manual;
        next_st_err = st_err;
        next_post_pending = post_pending;
        unique case (st_state)
            icl_pkg::ICL_ST_IDLE: begin
                if (man_start) begin
                    next_st_state = icl_pkg::ICL_ST_RUN;
                    next_st_manual = 1'b1;
                end else if (post_pending && sample_tick) begin
                    next_post_pending = 1'b0;
                    if (!post_dis) begin
                        next_st_state = icl_pkg::ICL_ST_RUN;
                    end
                end
            end
            icl_pkg::ICL_ST_RUN: begin
                if (selftest_done) begin
                    next_st_state = icl_pkg::ICL_ST_IDLE;
                    next_st_manual = 1'b0;
                    if (selftest_fail) begin
                        next_st_err = 1'b1;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_state <= icl_pkg::ICL_ST_IDLE;
            st_manual <= 1'b0;
            st_err <= 1'b0;
            post_pending <= 1'b1;
        end else begin
            st_state <= next_st_state;
            st_manual <= next_st_manual;
            st_err <= next_st_err;
            post_pending <= next_post_pending;
        end
    end

    // line drivers by priority: data-ready, alarm, general use
    always_comb begin
        next_line_q = '0;
        for (int i = 0; i < 2; i++) begin
            if (drdy_cfg[`ICL_MSC_EN_BIT] && (drdy_cfg[`ICL_MSC_SEL_BIT] == i[0])) begin
                next_line_q.oe[i] = 1'b1;
                next_line_q.level[i] = drdy_cfg[`ICL_MSC_POL_BIT] ? drdy_act : !drdy_act;
            end else if (alarm_drive[i]) begin
                next_line_q.oe[i] = 1'b1;
                next_line_q.level[i] = alarm_level[i];
            end else begin
                next_line_q.oe[i] = line_dir[i];
                next_line_q.level[i] = line_dat[i];
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            line_q <= '0;
        end else begin
            line_q <= next_line_q;
        end
    end

    // checks on the block's own behaviour
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    property p_fresh_set;
        sample_tick |=> fresh;
    endproperty
    a_fresh_set: assert property (p_fresh_set) else $error("new-data flag not set");
    property p_fresh_clear;
        rd_done && is_output_addr(frame_addr) && !sample_tick |=> !fresh;
    endproperty
    a_fresh_clear: assert property (p_fresh_clear) else $error("new-data not cleared");
    property p_fault_flag;
        rd_done && is_output_addr(frame_addr) |=> out_shift[`ICL_FLAG_FAULT] == $past(fault_any);
    endproperty
    a_fault_flag: assert property (p_fault_flag) else $error("error flag wrong");
    property p_fmt12;
        rd_done && (frame_addr[5:1] == 5'h01) |=>
            (out_shift[13:12] == 2'h0) && (out_shift[11:0] == $past(sample_q.supply));
    endproperty
    a_fmt12: assert property (p_fmt12) else $error("supply word format wrong");
    property p_tick_period;
        sample_tick |-> (int'(smp_cnt) + 1) >= (int'(smpl_cfg[6:0]) + 1)
            * (smpl_cfg[`ICL_SMPL_TB_BIT] ? TB_SLOW_CYCLES : TB_FAST_CYCLES);
    endproperty
    a_tick_period: assert property (p_tick_period) else $error("sample tick early");
    property p_sleep_end;
        $fell(asleep) |-> ($past(slp_left) == 8'h01) && ($past(half_cnt) != 32'h0);
    endproperty
    a_sleep_end: assert property (p_sleep_end) else $error("sleep ended early");
    property p_sleep_quiet;
        asleep |-> !sample_tick ##1 !sample_tick;
    endproperty
    a_sleep_quiet: assert property (p_sleep_quiet) else $error("sample while asleep");
    property p_avg_max;
        avg_power <= `ICL_AVG_MAX;
    endproperty
    a_avg_max: assert property (p_avg_max) else $error("averaging above maximum");
    property p_drdy_start;
        sample_tick && drdy_cfg[`ICL_MSC_EN_BIT] && !drdy_cfg[`ICL_MSC_SEL_BIT]
            && $stable(drdy_cfg) |-> ##2
            line_pin.oe[0] && (line_pin.level[0] == drdy_cfg[`ICL_MSC_POL_BIT]);
    endproperty
    a_drdy_start: assert property (p_drdy_start) else $error("data-ready pulse missing");
    property p_gpio_out;
        line_dir[1] && !(drdy_cfg[`ICL_MSC_EN_BIT] && drdy_cfg[`ICL_MSC_SEL_BIT])
            && !alarm_drive[1] |=> line_pin.oe[1] && (line_pin.level[1] == $past(line_dat[1]));
    endproperty
    a_gpio_out: assert property (p_gpio_out) else $error("line two not driven");
    property p_selftest_err;
        selftest_run && selftest_done && selftest_fail |=> st_err && !selftest_run;
    endproperty
    a_selftest_err: assert property (p_selftest_err) else $error("self-test error lost");

endmodule

// ---- testbench/icl_spi_host.sv ----
/*
 * host model: full-duplex 16-bit frames on the serial port, msb first.
 * assumes ref_clk runs; all pins change on its falling edge.
 */
module icl_spi_host (
    input wire logic ref_clk,
    input wire logic miso,
    output icl_pkg::icl_spi_s spi
);
    timeunit 1ns;
    timeprecision 1ps;
    // 25 ref_clk per phase gives a 2.5 mhz serial clock
    localparam int PH = 25;
    initial spi = '{sclk: 1'b1, cs_n: 1'b1, mosi: 1'b0};
    // one frame; rx gets what the device shifts out meanwhile
    task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
        @(negedge ref_clk) spi.cs_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            repeat (PH) @(negedge ref_clk);
            spi.sclk = 1'b0;
            spi.mosi = tx[i];
            repeat (PH) @(negedge ref_clk);
            spi.sclk = 1'b1;
            rx[i] = miso;
        end
        repeat (PH) @(negedge ref_clk);
        spi.cs_n = 1'b1;
        spi.mosi = ~tx[0]; // released line must not look valid
        repeat (4) @(negedge ref_clk);
    endtask
endmodule

// ---- testbench/test_icl_output_control.sv ----
/*
 * self-checking bench for the output-control block.
 * assumes shortened timers; registers reached only by serial frames.
 */
module test_icl_output_control;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    icl_pkg::icl_spi_s spi_in;
    logic spi_miso, sample_strobe, asleep, selftest_run;
    logic selftest_done = 1'b0;
    logic selftest_fail = 1'b0;
    icl_pkg::icl_sample_s sample_in = '0;
    logic [3:0] fault_causes = '0;
    logic [3:0] avg_power;
    logic [1:0] alarm_drive = '0;
    logic [1:0] alarm_level = '0;
    logic [1:0] line_in;
    icl_pkg::icl_line_s line_pin;
    logic [15:0] rd;
    logic sel, pol;
    int n_fail = 0;
    int n_tests = 0;
    int n, m, slept;
    logic [7:0] prd[3] = '{8'h01, 8'h05, 8'h93};
    int prd_len[3] = '{40, 120, 1600};
    logic [13:0] exp_d[8] = '{14'h0abe, 14'h2abc, 14'h1234, 14'h0ccc,
        14'h04fe, 14'h3fff, 14'h0001, 14'h2000};
    logic [7:0] drc[2] = '{8'h05, 8'h06};

    always #4 ref_clk = ~ref_clk;
    // lines are pulled low when nobody drives them
    assign line_in = line_pin.oe & line_pin.level;

    icl_output_control #(.TB_FAST_CYCLES(20), .TB_SLOW_CYCLES(80), .HALF_SEC_CYCLES(10)) DUT (
        .ref_clk(ref_clk), .rst(rst), .spi_in(spi_in), .spi_miso(spi_miso),
        .sample_in(sample_in), .sample_strobe(sample_strobe),
        .fault_causes(fault_causes), .avg_power(avg_power), .asleep(asleep),
        .selftest_run(selftest_run), .selftest_done(selftest_done),
        .selftest_fail(selftest_fail), .alarm_drive(alarm_drive),
        .alarm_level(alarm_level), .line_in(line_in), .line_pin(line_pin));
    icl_spi_host host (.ref_clk(ref_clk), .miso(spi_miso), .spi(spi_in));

    // front end finishes each self-test three clocks after it starts
    always @(posedge selftest_run) begin
        repeat (3) @(negedge ref_clk);
        selftest_done = 1'b1;
        @(negedge ref_clk) selftest_done = 1'b0;
    end
    // cycles spent asleep
    always @(negedge ref_clk) slept <= rst ? 0 : slept + int'(asleep);

    task automatic check(input string what, input logic [15:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        logic [15:0] x;
        host.xfer({2'b10, a, d}, x);
    endtask
    // read frame, then a dummy frame that carries the answer out
    task automatic chk_reg(input string what, input logic [5:0] a, input logic [15:0] e);
        logic [15:0] v;
        host.xfer({2'b00, a, 8'h00}, v);
        host.xfer(16'h0000, v);
        check(what, v, e);
    endtask
    task automatic wait_strobe(output int c);
        c = 0;
        do begin
            @(negedge ref_clk);
            c++;
        end while (sample_strobe !== 1'b1 && c < 20000);
        if (sample_strobe !== 1'b1)
            n_fail++;
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial begin
        #750us;
        n_fail++;
        tally_and_finish;
    end

    initial begin
        repeat (3) @(negedge ref_clk);
        rst = 1'b0;
        // reset values, unmapped and write-only places
        chk_reg("smpl", 6'h36, 16'h0001);
        chk_reg("avg", 6'h38, 16'h0004);
        chk_reg("ctrl", 6'h34, 16'h0000);
        chk_reg("sleep", 6'h3a, 16'h0000);
        chk_reg("unmapped", 6'h20, 16'h0000);
        chk_reg("status", 6'h3c, 16'h0000);
        // sample spacing for both time bases
        foreach (prd[i]) begin
            wr(6'h36, prd[i]);
            wait_strobe(n);
            wait_strobe(n);
            check("period", 16'(n), 16'(prd_len[i]));
        end
        // averaging exponent clamps at eight
        wr(6'h38, 8'h0c);
        chk_reg("avg max", 6'h38, 16'h0008);
        wr(6'h38, 8'h03);
        check("avg pin", 16'(avg_power), 16'h0003);
        // result words: flags on top, data lsb-justified
        sample_in = '{12'habe, 14'h2abc, 14'h1234, 12'hccc, 12'h4fe, 14'h3fff, 14'h0001, 14'h2000};
        wr(6'h36, 8'hff);
        wait_strobe(n);
        for (int i = 0; i <= 8; i++) begin
            host.xfer({2'b00, 6'(2 + 2 * i), 8'h00}, rd);
            if (i > 0)
                check("result", rd, {i == 1, 1'b0, exp_d[i-1]});
        end
        fault_causes = 4'h2;
        wait_strobe(n);
        chk_reg("ea", 6'h04, {2'b11, 14'h2abc});
        chk_reg("causes", 6'h3c, 16'h0004);
        fault_causes = 4'h0;
        // data-ready on both lines, both polarities, alarm on line one
        alarm_drive = 2'b01;
        wr(6'h36, 8'h93);
        foreach (drc[i]) begin
            sel = drc[i][0];
            pol = drc[i][1];
            wr(6'h34, drc[i]);
            wait_strobe(n);
            repeat (2) @(negedge ref_clk);
            check("drdy start", 16'(line_pin.level[sel]), 16'(pol));
            m = 0;
            repeat (1600) begin
                m += int'(line_pin.level[sel] === pol && line_pin.oe[sel] === 1'b1);
                @(negedge ref_clk);
            end
            check("drdy duty", 16'(m), 16'd320);
        end
        // general-purpose lines and alarm priority over them
        alarm_drive = 2'b00;
        wr(6'h34, 8'h00);
        wr(6'h32, 8'h02);
        wr(6'h33, 8'h02);
        chk_reg("line", 6'h32, 16'h0202);
        alarm_drive = 2'b01;
        alarm_level = 2'b01;
        chk_reg("line alarm", 6'h32, 16'h0302);
        alarm_drive = 2'b00;
        // manual self-test that fails
        selftest_fail = 1'b1;
        wr(6'h35, 8'h01);
        chk_reg("st error", 6'h3c, 16'h0001);
        chk_reg("st volatile", 6'h34, 16'h0000);
        // timed sleep survives serial traffic, ends by count
        slept = 0;
        wr(6'h3a, 8'hc8);
        wr(6'h3a, 8'h01);
        check("asleep", 16'(asleep), 16'h0001);
        chk_reg("sleep rd", 6'h3a, 16'h0000);
        wait_strobe(n);
        check("slept", 16'(slept), 16'd2000);
        // reset cuts a sleep short
        wr(6'h3a, 8'hc8);
        rst = 1'b1;
        @(negedge ref_clk) rst = 1'b0;
        check("wake", {asleep, avg_power}, 5'h04);
        tally_and_finish;
    end
endmodule
